// ==== light_proximity_sensor_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lpsr_consts.svh"

module light_proximity_sensor_regs #(
    parameter int PROX_CONV_US = `LPSR_PROX_CONV_US,
    parameter int LIGHT_PERIOD_US = `LPSR_LIGHT_PERIOD_US,
    parameter int GAP_UNIT_US = `LPSR_GAP_UNIT_US
) (
    input wire logic ref_clk, // 200 MHz core clock
    input wire logic arst_n, // async reset, active low
    input wire logic scl, // serial clock pin
    input wire logic sdaIn, // serial data pin level
    output logic sdaOut, // serial data drive value, always low
    output logic sdaOen, // low while pulling data line low
    input wire logic addrSel, // address select pin
    input wire logic [7:0] nearSample, // proximity converter code
    input wire logic [11:0] lightSample, // light converter code
    output lpsr_pkg::lpsr_front_s front, // front-end controls
    output logic intN // interrupt, active low
);
    import lpsr_pkg::*;

    // ********************************
    // helpers
    // ********************************
    // gap select to idle time, in microseconds
    function automatic logic [19:0] gapUs(input logic [2:0] sel);
        logic [6:0] units;
        unique case (sel)
            3'h7: units = 7'h00;
            3'h6: units = 7'h01;
            3'h5: units = 7'h04;
            3'h4: units = 7'h06;
            3'h3: units = 7'h08;
            3'h2: units = 7'h10;
            3'h1: units = 7'h20;
            3'h0: units = 7'h40;
        endcase
        gapUs = 20'(units * GAP_UNIT_US);
    endfunction

    // persistence code to hit count
    function automatic logic [4:0] persistLimit(input logic [1:0] code);
        unique case (code)
            2'h0: persistLimit = 5'h01;
            2'h1: persistLimit = 5'h04;
            2'h2: persistLimit = 5'h08;
            2'h3: persistLimit = 5'h10;
        endcase
    endfunction

    // hit counter saturates at sixteen so it cannot wrap back under the limit
    function automatic logic [4:0] nextHits(input logic [4:0] hits, input logic qual);
        if (!qual) begin
            nextHits = 5'h00;
        end else if (hits == 5'h10) begin
            nextHits = hits;
        end else begin
            nextHits = hits + 5'h01;
        end
    endfunction

    lpsr_state_s s;
    lpsr_state_s n;

    // read decode; holes and the reserved slot answer zero
    function automatic logic [7:0] regRead(input logic [7:0] a, input lpsr_state_s r);
        unique case (a)
            `LPSR_OFF_CFG: regRead = r.cfg;
            `LPSR_OFF_IRQ: regRead = r.irq;
            `LPSR_OFF_NLO: regRead = r.nearLow;
            `LPSR_OFF_NHI: regRead = r.nearHigh;
            `LPSR_OFF_LA: regRead = r.limA;
            `LPSR_OFF_LB: regRead = r.limB;
            `LPSR_OFF_LC: regRead = r.limC;
            `LPSR_OFF_NRES: regRead = r.nearRes;
            `LPSR_OFF_LRLO: regRead = r.lightRes[7:0];
            `LPSR_OFF_LRHI: regRead = {4'h0, r.lightRes[11:8]};
            `LPSR_OFF_TA: regRead = r.testA;
            `LPSR_OFF_TB: regRead = r.testB;
            default: regRead = 8'h00;
        endcase
    endfunction

    logic sclNow;
    logic sdaNow;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic wrEn;
    logic loadRd;
    logic [7:0] rdByte;
    logic tick;
    logic nearQual;
    logic lightQual;
    logic [11:0] lightLow;
    logic [11:0] lightHigh;
    logic [19:0] gap;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        n = s;
        wrEn = 1'b0;
        loadRd = 1'b0;
        gap = gapUs(s.cfg.proximityGapSelect);
        // pins pass two flops before anything looks at them
        n.sclSync = {s.sclSync[0], scl};
        n.sdaSync = {s.sdaSync[0], sdaIn};
        n.addrSync = {s.addrSync[0], addrSel};
        sclNow = s.sclSync[1];
        sdaNow = s.sdaSync[1];
        n.sclPrev = sclNow;
        n.sdaPrev = sdaNow;
        sclRise = sclNow & ~s.sclPrev;
        sclFall = ~sclNow & s.sclPrev;
        startCond = sclNow & s.sclPrev & s.sdaPrev & ~sdaNow;
        stopCond = sclNow & s.sclPrev & ~s.sdaPrev & sdaNow;

        // serial slave: start or stop break any transfer
        if (startCond) begin
            n.bus = BUS_ADDR;
            n.bitCnt = 4'h0;
            n.sdaOen = 1'b1;
        end else if (stopCond) begin
            n.bus = BUS_IDLE;
            n.sdaOen = 1'b1;
        end else begin
            unique case (s.bus)
                BUS_IDLE: begin
                end
                BUS_ADDR, BUS_PTR, BUS_WDATA: begin
                    if (sclRise && s.bitCnt != 4'h8) begin
                        n.shift = {s.shift[6:0], sdaNow};
                        n.bitCnt = s.bitCnt + 4'h1;
                    end else if (sclFall && s.bitCnt == 4'h8) begin
                        n.bitCnt = 4'h0;
                        n.bus = BUS_ACK;
                        n.sdaOen = 1'b0;
                        if (s.bus == BUS_ADDR) begin
                            n.nextBus = s.shift[0] ? BUS_RDATA : BUS_PTR;
                            // other addresses are left alone, no acknowledge
                            if (s.shift[7:1] != {`LPSR_SLAVE_HI, s.addrSync[1]}) begin
                                n.bus = BUS_IDLE;
                                n.sdaOen = 1'b1;
                            end
                        end else if (s.bus == BUS_PTR) begin
                            n.ptr = s.shift;
                            n.nextBus = BUS_WDATA;
                        end else begin
                            wrEn = 1'b1;
                            n.ptr = s.ptr + 8'h01;
                            n.nextBus = BUS_WDATA;
                        end
                    end
                end
                BUS_ACK: begin
                    if (sclFall) begin
                        n.sdaOen = 1'b1;
                        n.bus = s.nextBus;
                        loadRd = (s.nextBus == BUS_RDATA);
                    end
                end
                BUS_RDATA: begin
                    if (sclRise) begin
                        n.bitCnt = s.bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (s.bitCnt == 4'h8) begin
                            n.sdaOen = 1'b1;
                            n.bus = BUS_MACK;
                        end else begin
                            n.shift = {s.shift[6:0], 1'b0};
                            n.sdaOen = s.shift[6];
                        end
                    end
                end
                BUS_MACK: begin
                    if (sclRise) begin
                        n.nackSeen = sdaNow;
                    end else if (sclFall) begin
                        n.bus = s.nackSeen ? BUS_IDLE : BUS_RDATA;
                        loadRd = ~s.nackSeen;
                    end
                end
                default: begin
                    n.bus = BUS_IDLE;
                    n.sdaOen = 1'b1;
                end
            endcase
        end

        // read byte is fetched at the moment its first bit goes out; pointer steps on
        rdByte = regRead(s.ptr, s);
        if (loadRd) begin
            n.shift = rdByte;
            n.sdaOen = rdByte[7];
            n.bitCnt = 4'h0;
            n.ptr = s.ptr + 8'h01;
        end

        // register writes; results and the reserved slot ignore them
        if (wrEn) begin
            unique case (s.ptr)
                `LPSR_OFF_CFG: n.cfg = s.shift;
                `LPSR_OFF_IRQ: begin
                    n.irq = s.shift;
                    // flags only clear on a written zero, a one leaves them
                    n.irq.proximityEvent = s.irq.proximityEvent & s.shift[`LPSR_POS_PFLAG];
                    n.irq.lightEvent = s.irq.lightEvent & s.shift[`LPSR_POS_LFLAG];
                end
                `LPSR_OFF_NLO: n.nearLow = s.shift;
                `LPSR_OFF_NHI: n.nearHigh = s.shift;
                `LPSR_OFF_LA: n.limA = s.shift;
                `LPSR_OFF_LB: n.limB = s.shift;
                `LPSR_OFF_LC: n.limC = s.shift;
                `LPSR_OFF_TA: n.testA = s.shift;
                `LPSR_OFF_TB: n.testB = s.shift;
                default: begin
                end
            endcase
        end
        // one-microsecond enable so long timers stay twenty bits wide
        tick = (s.tickCnt == 8'(`LPSR_TICK_CYC - 1));
        n.tickCnt = tick ? 8'h00 : s.tickCnt + 8'h01;
        // proximity sequencer: convert, then idle for the chosen gap
        n.nearDone = 1'b0;
        n.proxRunPrev = s.cfg.proximityRun;
        if (!s.cfg.proximityRun) begin
            n.proxConv = 1'b0;
            n.proxTimer = 20'h00000;
        end else if (!s.proxRunPrev) begin
            n.proxConv = 1'b1;
            n.proxTimer = 20'(PROX_CONV_US);
        end else if (tick) begin
            n.proxTimer = s.proxTimer - 20'h00001;
            if (s.proxTimer == 20'h00001) begin
                if (s.proxConv) begin
                    n.nearDone = 1'b1;
                    n.proxConv = (gap == 20'h00000);
                    n.proxTimer = (gap == 20'h00000) ? 20'(PROX_CONV_US) : gap;
                end else begin
                    n.proxConv = 1'b1;
                    n.proxTimer = 20'(PROX_CONV_US);
                end
            end
        end
        // light sequencer: free-running period while enabled
        n.lightDone = 1'b0;
        n.lightRunPrev = s.cfg.lightRun;
        if (!s.cfg.lightRun) begin
            n.lightTimer = 20'h00000;
        end else if (!s.lightRunPrev) begin
            n.lightTimer = 20'(LIGHT_PERIOD_US);
        end else if (tick) begin
            n.lightTimer = s.lightTimer - 20'h00001;
            if (s.lightTimer == 20'h00001) begin
                n.lightDone = 1'b1;
                n.lightTimer = 20'(LIGHT_PERIOD_US);
            end
        end
        // results latch on completion; the window comparisons use the live nearSample and lightSample
        lightLow = {s.limB[3:0], s.limA};
        lightHigh = {s.limC, s.limB[7:4]};
        nearQual = (nearSample > s.nearHigh) || (nearSample < s.nearLow);
        lightQual = (lightSample > lightHigh) || (lightSample < lightLow);
        if (n.nearDone) begin
            n.nearRes = nearSample;
            n.proxHits = nextHits(s.proxHits, nearQual);
            if (nextHits(s.proxHits, nearQual) >= persistLimit(s.irq.proximityRepeatCount)) begin
                n.irq.proximityEvent = 1'b1;
            end
        end
        if (n.lightDone) begin
            n.lightRes = lightSample;
            n.lightHits = nextHits(s.lightHits, lightQual);
            if (nextHits(s.lightHits, lightQual) >= persistLimit(s.irq.lightRepeatCount)) begin
                n.irq.lightEvent = 1'b1;
            end
        end

        // interrupt pin follows the stored flags one cycle later
        n.intN = s.irq.combineAnd ? ~(s.irq.proximityEvent & s.irq.lightEvent)
                                  : ~(s.irq.proximityEvent | s.irq.lightEvent);

        // LED sinks only while a proximity conversion is running
        n.front.ledSinkPin = s.proxConv & s.cfg.proximityRun;
        n.front.ledSinkStrength = s.cfg.ledSinkStrength;
        n.front.lightLuxSpan = s.cfg.lightLuxSpan;
        n.front.lightSourceSelect = s.cfg.lightSourceSelect;
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.sclSync <= 2'h3;
            s.sdaSync <= 2'h3;
            s.sclPrev <= 1'b1;
            s.sdaPrev <= 1'b1;
            s.sdaOen <= 1'b1;
            s.intN <= 1'b1;
            s.nearHigh <= `LPSR_RST_NHI;
            s.limB <= `LPSR_RST_LB;
            s.limC <= `LPSR_RST_LC;
        end else begin
            s <= n;
        end
    end

    // open drain: the line is only ever pulled low
    assign sdaOut = 1'b0;
    assign sdaOen = s.sdaOen;
    assign front = s.front;
    assign intN = s.intN;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    a_flag_sticky: assert property (s.irq.proximityEvent && !(wrEn && s.ptr == `LPSR_OFF_IRQ)
        |=> s.irq.proximityEvent) else $error("proximity flag dropped without write");
    a_int_both: assert property (s.irq.proximityEvent && s.irq.lightEvent |=> !intN)
        else $error("interrupt not low with both flags");
    a_int_and_mode: assert property (s.irq.combineAnd && !s.irq.lightEvent |=> intN)
        else $error("interrupt low in and mode with one flag");
    a_prox_stop: assert property (!s.cfg.proximityRun |=> ##1 !front.ledSinkPin && !s.nearDone)
        else $error("proximity active while disabled");
    a_light_stop: assert property (!s.cfg.lightRun |=> s.lightTimer == 20'h00000 && !s.lightDone)
        else $error("light timer running while disabled");
    a_near_result: assert property (n.nearDone |=> s.nearRes == $past(nearSample))
        else $error("proximity result not captured");
    a_persist_one: assert property (n.nearDone && nearQual && s.irq.proximityRepeatCount == 2'h0
        |=> s.irq.proximityEvent) else $error("single hit did not set flag");
    a_light_window: assert property (n.lightDone && lightSample < lightLow
        && s.irq.lightRepeatCount == 2'h0 |=> s.irq.lightEvent) else $error("light low limit missed");
    a_gap_zero: assert property (s.nearDone && s.cfg.proximityRun && s.proxRunPrev
        && s.cfg.proximityGapSelect == 3'h7 |-> s.proxConv) else $error("no back to back conversion");
    a_reserved_zero: assert property (loadRd && s.ptr == `LPSR_OFF_RSVD |=> s.shift == 8'h00)
        else $error("reserved slot read not zero");
    a_front_cfg: assert property (##2 front.ledSinkStrength == $past(s.cfg.ledSinkStrength, 1)
        && front.lightSourceSelect == $past(s.cfg.lightSourceSelect, 1))
        else $error("front-end controls do not follow config");
endmodule

`default_nettype wire

// ==== light_proximity_sensor_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lpsr_consts.svh"

module light_proximity_sensor_regs_test;
    import lpsr_pkg::*;
    // ****************************************
    // bench for the sensor register block
    // ****************************************
    // shortened timers keep the run well under the cycle budget
    localparam int CONV_US = 3;
    localparam int LIGHT_US = 5;
    localparam int GAP_US = 1;
    localparam int TICK = 200;
    localparam logic [7:0] OFFS [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0E, 8'h0F};
    localparam logic [7:0] RSTV [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hF0,
        8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int GAPU [8] = '{64, 32, 16, 8, 6, 4, 1, 0};
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic addrSel = 1'b1;
    logic [7:0] nearSample = 8'h5A;
    logic [11:0] lightSample = 12'hABC;
    logic scl, sdaRel, sdaOut, sdaOen, intN, sdaLine;
    lpsr_front_s front;
    int err_total = 0;
    int comparisons = 0;

    // open drain: low if either side pulls, else the pull-up wins
    assign sdaLine = sdaRel & (sdaOen | sdaOut);

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    light_proximity_sensor_regs #(.PROX_CONV_US(CONV_US), .LIGHT_PERIOD_US(LIGHT_US), .GAP_UNIT_US(GAP_US)) i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOen(sdaOen), .addrSel(addrSel), .nearSample(nearSample), .lightSample(lightSample),
        .front(front), .intN(intN));

    lpsr_host i_host (.ref_clk(ref_clk), .sdaLine(sdaLine), .addrSel(addrSel), .scl(scl), .sdaRel(sdaRel));

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic n;
        i_host.regWr(a, d, 1'b0, n);
        check(12'(n), 12'h000, "write not acknowledged");
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic n;
        i_host.regRd(a, d, n);
        check(12'(n), 12'h000, "read not acknowledged");
        check(12'(d), 12'(exp), "register read");
    endtask

    // counts cycles until the led sink reaches lvl, gives up at bound
    task automatic waitLvl(input logic lvl, input int bound, output int n);
        n = 0;
        while (front.ledSinkPin !== lvl && n < bound) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    // main sequence
    initial begin
        int g;
        int w;
        int e;
        logic n;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 14; i++) begin
            rdChk(OFFS[i], RSTV[i]);
        end
        i_host.regWr(`LPSR_OFF_NHI, 8'h40, 1'b1, n);
        check(12'(n), 12'h001, "foreign address acknowledged");
        rdChk(`LPSR_OFF_NHI, 8'hFF);
        wr(`LPSR_OFF_NHI, 8'h40);
        rdChk(`LPSR_OFF_NHI, 8'h40);
        wr(`LPSR_OFF_LC, 8'h10);
        wr(`LPSR_OFF_LB, 8'h00);
        rdChk(`LPSR_OFF_LB, 8'h00);
        rdChk(`LPSR_OFF_LC, 8'h10);
        wr(`LPSR_OFF_NRES, 8'hFF);
        rdChk(`LPSR_OFF_NRES, 8'h00);
        wr(`LPSR_OFF_TA, 8'h00);
        wr(`LPSR_OFF_TB, 8'h00);
        wr(`LPSR_OFF_IRQ, 8'h01);
        rdChk(`LPSR_OFF_IRQ, 8'h01);
        wr(`LPSR_OFF_CFG, 8'h0B);
        rdChk(`LPSR_OFF_CFG, 8'h0B);
        check(12'(front.ledSinkStrength), 12'h001, "strong sink");
        check(12'(front.lightLuxSpan), 12'h001, "high lux");
        check(12'(front.lightSourceSelect), 12'h001, "infrared source");
        check(12'(front.ledSinkPin), 12'h000, "sink idle while stopped");
        // every gap code; waiting for a fresh rise skips a gap left from the old code
        for (int c = 7; c >= 0; c--) begin
            wr(`LPSR_OFF_CFG, {1'b1, 3'(c), 4'hB});
            waitLvl(1'b1, 15000, w);
            waitLvl(1'b0, 4 * CONV_US * TICK, w);
            waitLvl(1'b1, 15000, g);
            e = GAPU[c] * GAP_US * TICK;
            check(12'(g + TICK >= e && g <= e + TICK), 12'h001, "gap length");
            if (c != 7) begin
                waitLvl(1'b0, 4 * CONV_US * TICK, w);
                e = CONV_US * TICK;
                check(12'(w + TICK >= e && w <= e + TICK), 12'h001, "conversion length");
            end
        end
        rdChk(`LPSR_OFF_IRQ, 8'h81);
        check(12'(intN), 12'h001, "and-combined with one flag");
        wr(`LPSR_OFF_IRQ, 8'h80);
        repeat (2) @(posedge ref_clk);
        check(12'(intN), 12'h000, "or-combined with one flag");
        wr(`LPSR_OFF_CFG, 8'h00);
        nearSample <= 8'h33;
        repeat (4 * CONV_US * TICK) @(posedge ref_clk);
        check(12'(front.ledSinkPin), 12'h000, "sink after stop");
        check(12'(front.ledSinkStrength), 12'h000, "weak sink");
        check(12'(front.lightLuxSpan), 12'h000, "low lux");
        check(12'(front.lightSourceSelect), 12'h000, "visible source");
        rdChk(`LPSR_OFF_NRES, 8'h5A);
        wr(`LPSR_OFF_IRQ, 8'h00);
        rdChk(`LPSR_OFF_IRQ, 8'h00);
        check(12'(intN), 12'h001, "interrupt after clear");
        // light above the high limit, four hits needed
        wr(`LPSR_OFF_IRQ, 8'h02);
        wr(`LPSR_OFF_CFG, 8'h04);
        repeat (3 * LIGHT_US * TICK + LIGHT_US * TICK / 2) @(posedge ref_clk);
        check(12'(intN), 12'h001, "three light hits");
        repeat (LIGHT_US * TICK) @(posedge ref_clk);
        check(12'(intN), 12'h000, "four light hits");
        rdChk(`LPSR_OFF_IRQ, 8'h0A);
        rdChk(`LPSR_OFF_LRLO, 8'hBC);
        rdChk(`LPSR_OFF_LRHI, 8'h0A);
        // window moved so only the low limit trips; flags cleared, one hit is enough
        wr(`LPSR_OFF_LB, 8'h0F);
        wr(`LPSR_OFF_LC, 8'hFF);
        wr(`LPSR_OFF_IRQ, 8'h00);
        repeat (LIGHT_US * TICK + TICK) @(posedge ref_clk);
        rdChk(`LPSR_OFF_IRQ, 8'h08);
        check(12'(intN), 12'h000, "light below low limit");
        test_done();
    end

    // the tests need roughly 80000 cycles; a hang is cut short inside the run budget
    initial begin
        repeat (97000) @(posedge ref_clk);
        err_total++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        test_done();
    end
endmodule
`default_nettype wire

// ==== lpsr_consts.svh ====
`ifndef LPSR_CONSTS_SVH
`define LPSR_CONSTS_SVH
// register offsets
`define LPSR_OFF_RSVD 8'h00
`define LPSR_OFF_CFG 8'h01
`define LPSR_OFF_IRQ 8'h02
`define LPSR_OFF_NLO 8'h03
`define LPSR_OFF_NHI 8'h04
`define LPSR_OFF_LA 8'h05
`define LPSR_OFF_LB 8'h06
`define LPSR_OFF_LC 8'h07
`define LPSR_OFF_NRES 8'h08
`define LPSR_OFF_LRLO 8'h09
`define LPSR_OFF_LRHI 8'h0A
`define LPSR_OFF_TA 8'h0E
`define LPSR_OFF_TB 8'h0F
// reset values that are not zero
`define LPSR_RST_NHI 8'hFF
`define LPSR_RST_LB 8'hF0
`define LPSR_RST_LC 8'hFF
// field positions in irq_control
`define LPSR_POS_PFLAG 7
`define LPSR_POS_LFLAG 3
// upper six bits of the serial slave address
`define LPSR_SLAVE_HI 6'h22
// timing
`define LPSR_CLK_NS 5
`define LPSR_TICK_NS 1000
`define LPSR_TICK_CYC (`LPSR_TICK_NS / `LPSR_CLK_NS)
`define LPSR_PROX_CONV_US 540
`define LPSR_LIGHT_PERIOD_US 100000
`define LPSR_GAP_UNIT_US 12500
`endif

// ==== lpsr_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lpsr_consts.svh"

module lpsr_host (
    input wire logic ref_clk, // paces every bus phase
    input wire logic sdaLine, // resolved data line level
    input wire logic addrSel, // level strapped on the address pin
    output var logic scl, // serial clock, high while idle
    output var logic sdaRel // 1 lets the pull-up own the data line
);
    // ****************************************
    // serial host: clock low 7, high 6 cycles
    // ****************************************
    // clock only toggles inside frames, stands high between them
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // data moves 3 cycles after the fall, well clear of both clock edges
    task automatic bitOut(input logic b);
        tick(3);
        sdaRel <= b;
        tick(4);
        scl <= 1'b1;
        tick(6);
        scl <= 1'b0;
    endtask

    task automatic bitIn(output logic b);
        tick(3);
        sdaRel <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(3);
        b = sdaLine;
        tick(3);
        scl <= 1'b0;
    endtask

    // also serves as repeated start from a low clock
    task automatic start();
        tick(3);
        sdaRel <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(5);
        sdaRel <= 1'b0;
        tick(5);
        scl <= 1'b0;
    endtask

    task automatic stop();
        tick(3);
        sdaRel <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(5);
        sdaRel <= 1'b1;
        tick(6);
    endtask

    task automatic wrByte(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            bitOut(d[i]);
        end
        bitIn(nack);
    endtask

    task automatic rdByte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) begin
            bitIn(d[i]);
        end
        bitOut(last);
    endtask

    // pointer byte then one data byte; bad aims at the other strap
    task automatic regWr(input logic [7:0] a, input logic [7:0] d, input logic bad, output logic nack);
        logic n0, n1, n2;
        start();
        wrByte({`LPSR_SLAVE_HI, addrSel ^ bad, 1'b0}, n0);
        wrByte(a, n1);
        wrByte(d, n2);
        stop();
        nack = n0 | n1 | n2;
    endtask

    // set pointer, repeated start, one byte ended by a not-acknowledge
    task automatic regRd(input logic [7:0] a, output logic [7:0] d, output logic nack);
        logic n0, n1, n2;
        start();
        wrByte({`LPSR_SLAVE_HI, addrSel, 1'b0}, n0);
        wrByte(a, n1);
        start();
        wrByte({`LPSR_SLAVE_HI, addrSel, 1'b1}, n2);
        rdByte(d, 1'b1);
        stop();
        nack = n0 | n1 | n2;
    endtask
endmodule
`default_nettype wire

// ==== lpsr_pkg.sv ====
`default_nettype none
package lpsr_pkg;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_PTR = 3'b010,
        BUS_WDATA = 3'b011,
        BUS_RDATA = 3'b100,
        BUS_ACK = 3'b101,
        BUS_MACK = 3'b110
    } lpsr_bus_e;

    typedef struct packed {
        logic proximityRun;
        logic [2:0] proximityGapSelect;
        logic ledSinkStrength;
        logic lightRun;
        logic lightLuxSpan;
        logic lightSourceSelect;
    } lpsr_cfg_s;

    typedef struct packed {
        logic proximityEvent;
        logic [1:0] proximityRepeatCount;
        logic spare;
        logic lightEvent;
        logic [1:0] lightRepeatCount;
        logic combineAnd;
    } lpsr_irq_s;

    typedef struct packed {
        logic ledSinkPin;
        logic ledSinkStrength;
        logic lightLuxSpan;
        logic lightSourceSelect;
    } lpsr_front_s;

    typedef struct packed {
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic [1:0] addrSync;
        logic sclPrev;
        logic sdaPrev;
        lpsr_bus_e bus;
        lpsr_bus_e nextBus;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic nackSeen;
        logic sdaOen;
        logic [7:0] tickCnt;
        logic proxConv;
        logic proxRunPrev;
        logic [19:0] proxTimer;
        logic lightRunPrev;
        logic [19:0] lightTimer;
        lpsr_cfg_s cfg;
        lpsr_irq_s irq;
        logic [7:0] nearLow;
        logic [7:0] nearHigh;
        logic [7:0] limA;
        logic [7:0] limB;
        logic [7:0] limC;
        logic [7:0] nearRes;
        logic [11:0] lightRes;
        logic [7:0] testA;
        logic [7:0] testB;
        logic [4:0] proxHits;
        logic [4:0] lightHits;
        logic nearDone;
        logic lightDone;
        logic intN;
        lpsr_front_s front;
    } lpsr_state_s;
endpackage
`default_nettype wire
